/* File: design/scp_pkg.sv */
package scp_pkg;

    localparam int          INSTR_W         = 16;
    localparam int          BYTE_W          = 8;
    localparam int          ADDR_W          = 13;
    localparam int          IDX_W           = 10;
    localparam int          REG_DEPTH       = 567;

    localparam logic [12:0] ADDR_PORT_CFG   = 13'h0000;
    localparam logic [12:0] ADDR_RDBK_SEL   = 13'h0004;
    localparam logic [12:0] ADDR_UPDATE     = 13'h0232;
    localparam logic [12:0] ADDR_HIGH_BASE  = 13'h0B00;
    localparam logic [12:0] ADDR_LAST       = 13'h0B03;
    localparam logic [9:0]  IDX_HIGH_BASE   = 10'h233;

    localparam logic [7:0]  PORT_CFG_RST    = 8'h18;
    localparam logic [7:0]  RDBK_SEL_RST    = 8'h00;
    localparam logic [7:0]  UPDATE_RST      = 8'h00;
    localparam logic [7:0]  BLANK_RST       = 8'h00;

    localparam int          CFG_UNIDIR_HI   = 7;
    localparam int          CFG_LSB_HI      = 6;
    localparam int          CFG_LSB_LO      = 1;
    localparam int          CFG_UNIDIR_LO   = 0;
    localparam int          RDBK_ACTIVE_BIT = 0;
    localparam int          UPDATE_BIT      = 0;

    localparam logic [1:0]  LEN_STREAM      = 2'h3;
    localparam logic [3:0]  INSTR_LAST_BIT  = 4'hF;
    localparam logic [3:0]  BYTE_LAST_BIT   = 4'h7;
    localparam logic [1:0]  ABORT_HOLD      = 2'h2;

    typedef enum logic [1:0] {
        ST_INSTR,
        ST_WRITE,
        ST_READ,
        ST_HALT
    } scp_state_e;

    typedef struct packed {
        logic        rd;
        logic [1:0]  len;
        logic [12:0] addr;
    } scp_instr_s;

    typedef struct packed {
        logic        en;
        logic [12:0] addr;
        logic [7:0]  data;
    } scp_wr_s;

    function automatic logic reg_mapped(input logic [12:0] addr);
        return (addr <= ADDR_UPDATE) || ((addr >= ADDR_HIGH_BASE) && (addr <= ADDR_LAST));
    endfunction

    function automatic logic [9:0] reg_index(input logic [12:0] addr);
        if (addr <= ADDR_UPDATE) begin
            return addr[9:0];
        end else begin
            return IDX_HIGH_BASE + {8'h00, addr[1:0]};
        end
    endfunction

endpackage

/* File: design/scp_sync2.sv */
`timescale 1ns/1ps
module scp_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);

    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_nxt = rst_n ? d : RST_VAL;
        q_nxt    = rst_n ? meta_r : RST_VAL;
    end

    always_ff @(posedge clk) begin
        meta_r <= meta_nxt;
        q      <= q_nxt;
    end

endmodule

/* File: design/scp_regbank.sv */
`timescale 1ns/1ps
module scp_regbank
    import scp_pkg::*;
(
    input  wire logic        sclk,
    input  wire logic        reg_rst,
    input  wire scp_wr_s     wr,
    input  wire logic [12:0] rd_addr,
    input  wire logic        rd_active,
    output logic [7:0]       rd_data,
    output logic [7:0]       port_cfg,
    output logic             rdbk_active
);

    logic [7:0] shadow_r   [REG_DEPTH];
    logic [7:0] shadow_nxt [REG_DEPTH];
    logic [7:0] active_r   [REG_DEPTH];
    logic [7:0] active_nxt [REG_DEPTH];
    logic       commit;
    logic [9:0] wr_idx;

    assign wr_idx = reg_index(wr.addr);
    assign commit = wr.en && (wr.addr == ADDR_UPDATE) && wr.data[UPDATE_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < REG_DEPTH; gi++) begin : g_entry
            localparam logic [7:0] RST_V = (gi == 0) ? PORT_CFG_RST : BLANK_RST;
            always_comb begin
                shadow_nxt[gi] = shadow_r[gi];
                if (wr.en && reg_mapped(wr.addr) && (wr_idx == 10'(gi))) begin
                    shadow_nxt[gi] = wr.data;
                    if (wr.addr == ADDR_UPDATE) begin
                        shadow_nxt[gi][UPDATE_BIT] = 1'b0;
                    end
                end
                // Every buffered byte becomes active on the same edge.
                active_nxt[gi] = commit ? shadow_nxt[gi] : active_r[gi];
            end
            always_ff @(posedge sclk or posedge reg_rst) begin
                if (reg_rst) begin
                    shadow_r[gi] <= RST_V;
                    active_r[gi] <= RST_V;
                end else begin
                    shadow_r[gi] <= shadow_nxt[gi];
                    active_r[gi] <= active_nxt[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        rd_data = 8'h00;
        if (reg_mapped(rd_addr)) begin
            rd_data = rd_active ? active_r[reg_index(rd_addr)]
                                : shadow_r[reg_index(rd_addr)];
        end
    end

    // Port control acts from the buffer at once, with no update needed.
    assign port_cfg    = shadow_r[0];
    assign rdbk_active = shadow_r[4][RDBK_ACTIVE_BIT];

endmodule

/* File: design/scp_port.sv */
`timescale 1ns/1ps
// How it works
// - Each cycle starts with a sixteen-bit instruction, then the data phase.
// - Instruction holds read flag on top, two length bits, thirteen address bits.
// - Length code gives one, two, three bytes, or streaming.
// - Write data bits are taken from the data pin on rising serial clock.
// - Chip select may rise between bytes to stall, except in streaming; a write resumes on return, a read resumes with its next bit undriven.
// - Chip select rising mid-byte resets the port and drops the transfer.
// - Writes go to a buffer; the self-clearing update bit commits all at once.
// - Reads shift out one to three bytes, or stream until chip select rises or the update register is passed.
// - Each read bit is driven on the falling serial clock so it is valid at the next rising edge unless chip select rises between.
// - Read data uses the data pin unless config bits seven and zero are set.
// - Readback select bit zero picks buffer or active register contents.
// - Config bits one and six select LSB-first at once, without update.
// - Instruction and data shift MSB first or LSB first per the order.
// - Address steps down in MSB-first order, up in LSB-first order.
// - Streaming ends after the update register address in either direction.
// - Only long instructions; the config reset value sets bits four and three.
// - Addresses zero through 0x232 and 0xB00 through 0xB03 are decoded; the gap between is not.
// - Both output pins float while chip select is high.
module scp_port
    import scp_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic sdio_in,
    output logic      sdio_out,
    output logic      sdio_oe,
    output logic      readback_output_pin,
    output logic      readback_output_pin_oe,
    output logic      port_selected
);

    ////////////////////////////////////////////////////////////////////////////
    // System clock side: chip select watch and reset generation.

    logic       cs_sync;
    logic       abort_sync;
    logic       abort_need_r;
    logic       cs_prev_r;
    logic       cs_prev_nxt;
    logic       port_rst_r;
    logic       port_rst_nxt;
    logic       reg_rst_r;
    logic       reg_rst_nxt;
    logic [1:0] hold_r;
    logic [1:0] hold_nxt;
    logic       selected_nxt;

    scp_sync2 #(
        .RST_VAL (1'b1)
    ) u_cs_sync (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .d     (cs_n),
        .q     (cs_sync)
    );

    scp_sync2 #(
        .RST_VAL (1'b0)
    ) u_abort_sync (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .d     (abort_need_r),
        .q     (abort_sync)
    );

    // The serial clock stands still while chip select is high, so the
    // port reset is raised and dropped there without an edge to race.
    always_comb begin
        cs_prev_nxt  = cs_sync;
        reg_rst_nxt  = !rst_n;
        selected_nxt = !cs_sync;
        hold_nxt     = hold_r;
        port_rst_nxt = 1'b0;
        if (!rst_n) begin
            hold_nxt     = ABORT_HOLD;
            port_rst_nxt = 1'b1;
            selected_nxt = 1'b0;
        end else if (cs_sync && !cs_prev_r && abort_sync) begin
            hold_nxt     = ABORT_HOLD;
            port_rst_nxt = 1'b1;
        end else if (hold_r != 2'h0) begin
            hold_nxt     = hold_r - 2'h1;
            port_rst_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        cs_prev_r     <= cs_prev_nxt;
        reg_rst_r     <= reg_rst_nxt;
        hold_r        <= hold_nxt;
        port_rst_r    <= port_rst_nxt;
        port_selected <= selected_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    scp_wr_s     wr_c;
    logic [12:0] rd_addr_c;
    logic [7:0]  rd_data;
    logic [7:0]  port_cfg;
    logic        rdbk_active;
    logic        lsb_first;
    logic        unidir;

    scp_regbank u_regbank (
        .sclk        (sclk),
        .reg_rst     (reg_rst_r),
        .wr          (wr_c),
        .rd_addr     (rd_addr_c),
        .rd_active   (rdbk_active),
        .rd_data     (rd_data),
        .port_cfg    (port_cfg),
        .rdbk_active (rdbk_active)
    );

    assign lsb_first = port_cfg[CFG_LSB_HI] && port_cfg[CFG_LSB_LO];
    assign unidir    = port_cfg[CFG_UNIDIR_HI] && port_cfg[CFG_UNIDIR_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock side: instruction and data phases.

    scp_state_e  state_r;
    scp_state_e  state_nxt;
    scp_instr_s  instr_r;
    scp_instr_s  instr_nxt;
    scp_instr_s  word_c;
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic [3:0]  bit_cnt_r;
    logic [3:0]  bit_cnt_nxt;
    logic [12:0] addr_r;
    logic [12:0] addr_nxt;
    logic [12:0] step_addr;
    logic [1:0]  left_r;
    logic [1:0]  left_nxt;
    logic [7:0]  tx_r;
    logic [7:0]  tx_nxt;
    logic [7:0]  byte_c;
    logic        abort_nxt;
    logic        byte_end;
    logic        streaming;

    // Wrapping down past zero lands on the update register.
    function automatic logic [12:0] next_addr(input logic [12:0] a, input logic up);
        if (up) begin
            return 13'(a + 13'h0001);
        end else if (a == ADDR_PORT_CFG) begin
            return ADDR_UPDATE;
        end else begin
            return 13'(a - 13'h0001);
        end
    endfunction

    always_comb begin
        shift_nxt = lsb_first ? {sdio_in, shift_r[15:1]} : {shift_r[14:0], sdio_in};
        byte_c    = lsb_first ? {sdio_in, shift_r[15:9]} : {shift_r[6:0], sdio_in};
        word_c    = scp_instr_s'(shift_nxt);
        step_addr = next_addr(addr_r, lsb_first);
        rd_addr_c = (state_r == ST_INSTR) ? word_c.addr : step_addr;
        streaming = (instr_r.len == LEN_STREAM);
        byte_end  = (bit_cnt_r == BYTE_LAST_BIT);
    end

    always_comb begin
        state_nxt   = state_r;
        instr_nxt   = instr_r;
        addr_nxt    = addr_r;
        left_nxt    = left_r;
        tx_nxt      = tx_r;
        bit_cnt_nxt = 4'(bit_cnt_r + 4'h1);
        wr_c        = '0;
        case (state_r)
            ST_INSTR: begin
                if (bit_cnt_r == INSTR_LAST_BIT) begin
                    // Sixteen bits gathered: decode and open the data phase.
                    instr_nxt   = word_c;
                    addr_nxt    = word_c.addr;
                    left_nxt    = word_c.len;
                    tx_nxt      = rd_data;
                    bit_cnt_nxt = 4'h0;
                    state_nxt   = word_c.rd ? ST_READ : ST_WRITE;
                end
            end
            ST_WRITE, ST_READ: begin
                if (byte_end) begin
                    bit_cnt_nxt = 4'h0;
                    if (state_r == ST_WRITE) begin
                        wr_c.en   = 1'b1;
                        wr_c.addr = addr_r;
                        wr_c.data = byte_c;
                    end
                    if (!streaming && (left_r == 2'h0)) begin
                        state_nxt = ST_INSTR;
                    end else if (streaming && (addr_r == ADDR_UPDATE)) begin
                        state_nxt = ST_HALT;
                    end else begin
                        addr_nxt = step_addr;
                        left_nxt = streaming ? left_r : 2'(left_r - 2'h1);
                        tx_nxt   = rd_data;
                    end
                end
            end
            default: begin
                bit_cnt_nxt = bit_cnt_r;
            end
        endcase
        // A partial byte or an open stream must be torn down when chip select rises.
        // The instruction has a byte boundary after its eighth bit as well.
        abort_nxt = (bit_cnt_nxt[2:0] != 3'h0) ||
                    ((state_nxt != ST_INSTR) && (instr_nxt.len == LEN_STREAM));
    end

    // Between bytes the state simply waits; outside streaming a stall loses no state.
    always_ff @(posedge sclk or posedge port_rst_r) begin
        if (port_rst_r) begin
            state_r      <= ST_INSTR;
            instr_r      <= '0;
            shift_r      <= 16'h0000;
            bit_cnt_r    <= 4'h0;
            addr_r       <= 13'h0000;
            left_r       <= 2'h0;
            tx_r         <= 8'h00;
            abort_need_r <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            instr_r      <= instr_nxt;
            shift_r      <= shift_nxt;
            bit_cnt_r    <= bit_cnt_nxt;
            addr_r       <= addr_nxt;
            left_r       <= left_nxt;
            tx_r         <= tx_nxt;
            abort_need_r <= abort_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readback drivers, launched on the falling serial clock edge.

    logic dout_nxt;
    logic sdio_oe_nxt;
    logic rb_oe_nxt;
    logic reading;

    always_comb begin
        reading     = (state_r == ST_READ);
        dout_nxt    = lsb_first ? tx_r[bit_cnt_r[2:0]]
                                : tx_r[3'(BYTE_LAST_BIT[2:0] - bit_cnt_r[2:0])];
        sdio_oe_nxt = reading && !unidir;
        rb_oe_nxt   = reading && unidir;
    end

    // Chip select high forces both pins to float at once.
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            sdio_out               <= 1'b0;
            sdio_oe                <= 1'b0;
            readback_output_pin    <= 1'b0;
            readback_output_pin_oe <= 1'b0;
        end else begin
            sdio_out               <= dout_nxt;
            sdio_oe                <= sdio_oe_nxt;
            readback_output_pin    <= dout_nxt;
            readback_output_pin_oe <= rb_oe_nxt;
        end
    end

endmodule

/* File: verif/scp_port_checker.sv */
`timescale 1ns/1ps
module scp_port_checker
    import scp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic readback_output_pin,
    input wire logic readback_output_pin_oe,
    input wire logic port_selected
);
    logic [7:0] bit_cnt_r;
    logic [7:0] bit_cnt_nxt;
    ////////////////////
    // Chip select clears the count at once, so a stall restarts it on a byte boundary.
    always_comb begin
        bit_cnt_nxt = bit_cnt_r + 8'h01;
    end
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_r <= 8'h00;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
        end
    end
    ////////////////////
    a_pins_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cs_n |-> !sdio_oe && !readback_output_pin_oe && !sdio_out)
        else $error("pin driven while deselected");
    a_oe_exclusive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(sdio_oe && readback_output_pin_oe)) else $error("both pins driven");
    a_pins_same: assert property (@(posedge sys_clk) disable iff (!rst_n)
        readback_output_pin_oe |-> readback_output_pin == sdio_out) else $error("pin mismatch");
    a_bit_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !cs_n && sclk && $past(sclk) |-> $stable(sdio_out)) else $error("bit moved on high clock");
    a_oe_byte: assert property (@(negedge sclk) disable iff (!rst_n || cs_n)
        $rose(sdio_oe) |-> sdio_oe [*8]) else $error("read byte cut short");
    a_oe_stop: assert property (@(negedge sclk) disable iff (!rst_n || cs_n)
        $fell(sdio_oe) |-> bit_cnt_r[2:0] == 3'h1) else $error("read ended off boundary");
    a_sel_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(cs_n) |-> ##[1:6] port_selected) else $error("select not seen");
    a_sel_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(cs_n) |-> ##[1:6] !port_selected) else $error("deselect not seen");
    c_read_bidir: cover property (@(posedge sys_clk) $rose(sdio_oe));
    c_read_unidir: cover property (@(posedge sys_clk) $rose(readback_output_pin_oe));
    c_selected: cover property (@(posedge sys_clk) $rose(port_selected));
endmodule

bind scp_port scp_port_checker chk (
    .sys_clk, .rst_n, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe,
    .readback_output_pin, .readback_output_pin_oe, .port_selected
);

/* File: verif/scp_host_model.sv */
`timescale 1ns/1ps
module scp_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe,
    input  wire logic readback_output_pin,
    input  wire logic readback_output_pin_oe
);
    logic drv = 1'b0;
    logic hbit = 1'b0;
    logic flt = 1'b0;
    // A clean rising chip select clears the output drivers before the first frame.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        #1;
        cs_n = 1'b1;
    end
    ////////////////////
    // An undriven line toggles, so a stale bit never passes for read data.
    always @(sclk) flt = ~flt;
    assign sdio_in = sdio_oe ? sdio_out : (drv ? hbit : flt);
    ////////////////////
    task automatic xfer(input logic lsb, input logic uni, input logic [15:0] ins,
                        input logic [7:0] wd[$], input int nb, input int cut,
                        input int stall, output logic [7:0] rd[$]);
        logic       bq [$];
        logic [7:0] b;
        logic       s;
        b = 8'h00;
        rd = {};
        for (int i = 0; i < 16; i++) bq.push_back(lsb ? ins[i] : ins[15 - i]);
        foreach (wd[k]) for (int i = 0; i < 8; i++) bq.push_back(lsb ? wd[k][i] : wd[k][7 - i]);
        cs_n = 1'b0;
        #40;
        for (int n = 0; n < 16 + 8 * nb && n != cut; n++) begin
            if (n == stall) begin
                cs_n = 1'b1;
                #200;
                cs_n = 1'b0;
                #40;
            end
            drv = n < 16 || !ins[15];
            hbit = n < bq.size() ? bq[n] : 1'b0;
            #40;
            s = uni ? (readback_output_pin_oe ? readback_output_pin : flt) : sdio_in;
            b = lsb ? {s, b[7:1]} : {b[6:0], s};
            sclk = 1'b1;
            #40;
            sclk = 1'b0;
            if (n >= 16 && n % 8 == 7) rd.push_back(b);
        end
        drv = 1'b0;
        #40;
        cs_n = 1'b1;
        #200;
    endtask
endmodule

/* File: verif/scp_port_test.sv */
`timescale 1ns/1ps
module scp_port_test
    import scp_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sclk, cs_n, sdio_in, sdio_out, sdio_oe, port_selected;
    logic        readback_output_pin, readback_output_pin_oe;
    logic        lsb = 1'b0;
    logic        uni = 1'b0;
    int          num_errors = 0;
    int          comparisons = 0;
    int          stall_at = -1;
    int          cut_at = -1;
    logic [7:0]  buf_m [0:1023];
    logic [7:0]  act_m [0:1023];
    logic [7:0]  d [$];
    logic [7:0]  got [$];
    logic [12:0] a;
    always #5 sys_clk = ~sys_clk;
    scp_port uut (.sys_clk, .rst_n, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe,
        .readback_output_pin, .readback_output_pin_oe, .port_selected);
    scp_host_model host (.sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe,
        .readback_output_pin, .readback_output_pin_oe);
    ////////////////////
    function automatic logic [9:0] step(input logic [12:0] s, input int k);
        logic [9:0] v;
        v = s[9:0];
        repeat (k) v = lsb ? v + 10'h001 : (v == 10'h000 ? 10'h232 : v - 10'h001);
        return v;
    endfunction
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [12:0] s, input logic [1:0] len);
        logic [9:0] i;
        host.xfer(lsb, uni, {1'b0, len, s}, d, d.size(), cut_at, stall_at, got);
        if (cut_at < 0 && (s <= 13'h0232 || s >= 13'h0B00)) begin
            foreach (d[k]) begin
                i = step(s, k);
                buf_m[i] = d[k];
                if (i == 10'h232 && d[k][0]) begin
                    buf_m[i][0] = 1'b0;
                    act_m = buf_m;
                end
                if (len == 2'h3 && i == 10'h232) break;
            end
        end
    endtask
    task automatic rd(input logic [12:0] s, input logic [1:0] len, input int nb);
        host.xfer(lsb, uni, {1'b1, len, s}, d, nb, -1, -1, got);
        foreach (got[k]) check8("read byte", buf_m[4][0] ? act_m[step(s, k)] : buf_m[step(s, k)], got[k]);
    endtask
    task automatic done(input int t);
        $display("test %0d finished", t);
    endtask
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////
    initial begin
        #400000;
        num_errors++;
        final_report();
    end
    initial begin
        foreach (buf_m[i]) buf_m[i] = 8'h00;
        buf_m[0] = 8'h18;
        act_m = buf_m;
        void'($urandom(87552));
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        #3;
        rd(13'h0000, 2'h0, 1);
        done(1);
        for (int t = 0; t < 6; t++) begin
            a = 13'h0010 + 13'($urandom % 512);
            d = {};
            repeat (t % 3 + 1) d.push_back(8'($urandom));
            wr(a, 2'(t % 3));
            rd(a, 2'(t % 3), t % 3 + 1);
        end
        d = {8'h01};
        wr(13'h0004, 2'h0);
        rd(a, 2'h2, 3);
        wr(13'h0232, 2'h0);
        rd(a, 2'h2, 3);
        rd(13'h0232, 2'h0, 1);
        d = {8'h00};
        wr(13'h0004, 2'h0);
        done(2);
        d = {8'h3C, 8'hC3, 8'h18, 8'h00, 8'h77};
        wr(13'h0002, 2'h3);
        rd(13'h0002, 2'h3, 4);
        rd(13'h0231, 2'h0, 1);
        d = {8'h5A};
        wr(13'h0000, 2'h0);
        lsb = 1'b1;
        d = {8'($urandom), 8'($urandom), 8'($urandom)};
        wr(13'h0100, 2'h2);
        rd(13'h0100, 2'h2, 3);
        d = {8'h18};
        wr(13'h0000, 2'h0);
        lsb = 1'b0;
        done(3);
        d = {8'h99};
        wr(13'h0000, 2'h0);
        uni = 1'b1;
        rd(13'h0102, 2'h2, 3);
        d = {8'h18};
        wr(13'h0000, 2'h0);
        uni = 1'b0;
        d = {8'hA5, 8'h5A};
        stall_at = 24;
        wr(13'h0041, 2'h1);
        stall_at = -1;
        rd(13'h0041, 2'h1, 2);
        stall_at = 8;
        wr(13'h0043, 2'h1);
        stall_at = -1;
        rd(13'h0043, 2'h1, 2);
        cut_at = 21;
        d = {8'hFF};
        wr(13'h0041, 2'h0);
        cut_at = -1;
        rd(13'h0041, 2'h0, 1);
        done(4);
        d = {8'($urandom)};
        wr(13'h0B03, 2'h0);
        rd(13'h0B03, 2'h0, 1);
        wr(13'h0300, 2'h0);
        rd(13'h0300, 2'h0, 1);
        done(5);
        final_report();
    end
endmodule
